/* File: plld_top.sv */
// PLL digital lock indicator, analog pulse indicator, divider delays and N value
`timescale 1ns/100ps
//
// Notes on behaviour
// R1: Reference and feedback paths each have a three-bit delay cell, about 1 ns.
// R2: Each delay cell can be enabled or bypassed independently.
// R3: Lock pin, status pin and reference monitor pin each have own output mux.
// R4: Lock declared after selected count of consecutive in-window compare cycles.
// R5: Lock drops immediately on one single cycle beyond the unlock window.
// R6: Unlock window is wider than lock window, giving hysteresis.
// R7: Window timing depends on window select, antibacklash width and count.
// R8: User keeps compare period longer than the unlock window.
// R9: User may fit lock pin capacitor for very low loop bandwidths.
// R10: Analog indicator offers pull-down and pull-up open-drain pulse modes.
// R11: User keeps prescaler input within limits in two-by-three mode.
// R12: Fixed divide with B equal one bypasses A and B counters.
// R13: Fixed divide ignores A and divides by P times B.
// R14: Total division is P times B plus A, P from 2 to 32.
// R15: Saturating in-window counter, cleared by any out-of-window cycle.
module plld_top
    import plld_pkg::*;
#(
    parameter int B_WIDTH = 13
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Phase detector edges (asynchronous pins)
    input wire logic ref_edge,
    input wire logic fb_edge,
    // Configuration
    input wire plld_cfg_s cfg,
    input wire plld_dly_s dly,
    input wire plld_sel_e lock_pin_sel,
    input wire plld_sel_e status_pin_sel,
    input wire plld_sel_e reference_monitor_pin_pin_sel,
    input wire logic analog_pullup_mode,
    input wire plld_mode_e prescaler_mode,
    input wire logic [5:0] prescaler_p,
    input wire logic [5:0] a_count,
    input wire logic [B_WIDTH-1:0] b_count,
    // Indications and results
    output logic digital_lock_indicator,
    output logic lock_pin_val,
    output logic lock_pin_oe,
    output logic status_pin,
    output logic reference_monitor_pin,
    output logic [2:0] ref_delay_code,
    output logic [2:0] fb_delay_code,
    output logic [B_WIDTH+6:0] n_total
);

    // Refuse B widths that the division product cannot serve
    if (B_WIDTH < 2 || B_WIDTH > 20) begin : g_bad_width
        $error("B_WIDTH out of range");
    end

    // ==========================================
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_ff;
    logic rst_s_n;
    logic [1:0] ref_sync_ff, fb_sync_ff;
    logic ref_prev_ff, fb_prev_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_s_n = rst_sync_ff[1];

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ref_sync_ff <= 2'h0;
            fb_sync_ff <= 2'h0;
            ref_prev_ff <= 1'b0;
            fb_prev_ff <= 1'b0;
        end else begin
            ref_sync_ff <= {ref_sync_ff[0], ref_edge};
            fb_sync_ff <= {fb_sync_ff[0], fb_edge};
            ref_prev_ff <= ref_sync_ff[1];
            fb_prev_ff <= fb_sync_ff[1];
        end
    end

    logic ref_rise, fb_rise;
    assign ref_rise = ref_sync_ff[1] & ~ref_prev_ff;
    assign fb_rise = fb_sync_ff[1] & ~fb_prev_ff;

    // ==========================================
    // Window thresholds; a wider unlock window prevents chatter
    logic [7:0] lock_win, unlock_win;
    logic [10:0] need_cnt;
    always_comb begin
        lock_win = PLLD_LOCK_WIN_BASE + {6'h00, cfg.abl_width};        // R7
        unlock_win = PLLD_UNLOCK_WIN_BASE + {5'h00, cfg.abl_width, 1'b0}; // R6
        if (cfg.win_sel) begin
            lock_win = {lock_win[6:0], 1'b0};                           // R7
            unlock_win = {unlock_win[6:0], 1'b0};
        end
        unique case (cfg.cnt_sel)
            2'b00: need_cnt = PLLD_CNT_5;                               // R4
            2'b01: need_cnt = PLLD_CNT_16;
            2'b10: need_cnt = PLLD_CNT_64;
            2'b11: need_cnt = PLLD_CNT_255;
        endcase
    end

    a_window_order: assert property (@(posedge clk) disable iff (!rst_s_n) // R6
        lock_win < unlock_win) else $error("no hysteresis");

    // ==========================================
    // Edge difference measurement, one result per compare cycle
    typedef enum logic [1:0] {
        PLLD_IDLE = 2'b00,
        PLLD_WAIT = 2'b01
    } plld_st_e;
    plld_st_e st_ff, nxt_st;
    logic [7:0] diff_ff, nxt_diff;
    logic done_ff, nxt_done;
    logic [10:0] run_ff, nxt_run;
    logic lock_ff, nxt_lock;

    always_comb begin
        nxt_st = st_ff;
        nxt_diff = diff_ff;
        nxt_done = 1'b0;
        unique case (st_ff)
            PLLD_IDLE: begin
                nxt_diff = 8'h00;
                if (ref_rise && fb_rise) begin
                    nxt_done = 1'b1;
                end else if (ref_rise || fb_rise) begin
                    nxt_st = PLLD_WAIT;
                end
            end
            PLLD_WAIT: begin
                if (diff_ff != 8'hFF) begin
                    nxt_diff = diff_ff + 8'h01;
                end
                if (ref_rise || fb_rise) begin
                    nxt_done = 1'b1;
                    nxt_st = PLLD_IDLE;
                end
            end
            default: nxt_st = PLLD_IDLE;
        endcase
    end

    // Consecutive count and lock decision
    always_comb begin
        nxt_run = run_ff;
        nxt_lock = lock_ff;
        if (done_ff) begin
            if (diff_ff < lock_win) begin
                if (run_ff != 11'h7FF) begin
                    nxt_run = run_ff + 11'h001;                         // R15
                end
                if (run_ff + 11'h001 >= need_cnt) begin
                    nxt_lock = 1'b1;                                    // R4
                end
            end else begin
                nxt_run = 11'h000;                                      // R15
            end
            if (diff_ff > unlock_win) begin
                nxt_lock = 1'b0;                                        // R5
            end
        end
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            st_ff <= PLLD_IDLE;
            diff_ff <= 8'h00;
            done_ff <= 1'b0;
            run_ff <= 11'h000;
            lock_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            diff_ff <= nxt_diff;
            done_ff <= nxt_done;
            run_ff <= nxt_run;
            lock_ff <= nxt_lock;
        end
    end

    // Closing compare results, inside the lock window or beyond the unlock window
    sequence s_near_result;
        done_ff && diff_ff < lock_win;
    endsequence
    sequence s_far_result;
        done_ff && diff_ff > unlock_win;
    endsequence

    a_unlock_drop: assert property (@(posedge clk) disable iff (!rst_s_n) // R5
        s_far_result |=> !lock_ff) else $error("lock held");
    a_lock_on_run: assert property (@(posedge clk) disable iff (!rst_s_n) // R4
        s_near_result ##0 (run_ff + 11'h001 >= need_cnt) |=> lock_ff) else $error("late lock");
    a_lock_needs_run: assert property (@(posedge clk) disable iff (!rst_s_n) // R4
        $rose(lock_ff) |-> $past(run_ff) + 11'h001 >= $past(need_cnt)) else $error("early lock");
    a_run_clears: assert property (@(posedge clk) disable iff (!rst_s_n) // R15
        done_ff && diff_ff >= lock_win |=> run_ff == 11'h000) else $error("run kept");

    // ==========================================
    // Analog indicator: short pulse per edge mismatch, open-drain on the lock pin, driven on the status and reference monitor pins
    logic mismatch;
    assign mismatch = (st_ff == PLLD_WAIT);

    function automatic logic pick(input plld_sel_e s, input logic dig, input logic ana);
        logic r;
        r = 1'b0;
        unique case (s)
            PLLD_SEL_LOW: r = 1'b0;
            PLLD_SEL_DIGITAL: r = dig;
            PLLD_SEL_ANALOG: r = ana;
            PLLD_SEL_HIGH: r = 1'b1;
        endcase
        return r;
    endfunction

    // Pin muxes and registered outputs
    logic nxt_lock_o, nxt_lock_oe, nxt_status, nxt_reference_monitor_pin, ana_level;
    logic [2:0] nxt_ref_code, nxt_fb_code;
    logic [B_WIDTH+6:0] nxt_n;
    always_comb begin
        // Pull-down drives low pulses, pull-up drives high pulses
        ana_level = analog_pullup_mode ? mismatch : ~mismatch;          // R10
        nxt_lock_o = pick(lock_pin_sel, lock_ff, ana_level);            // R3
        nxt_lock_oe = 1'b1;
        if (lock_pin_sel == PLLD_SEL_ANALOG) begin
            nxt_lock_o = analog_pullup_mode;                            // R10
            nxt_lock_oe = mismatch;
        end
        nxt_status = pick(status_pin_sel, lock_ff, ana_level);          // R3
        nxt_reference_monitor_pin = pick(reference_monitor_pin_pin_sel, lock_ff, ana_level);          // R3
        // Disabled cell passes zero delay
        nxt_ref_code = dly.ref_en ? dly.ref_val : PLLD_DELAY_RST;       // R1 R2
        nxt_fb_code = dly.fb_en ? dly.fb_val : PLLD_DELAY_RST;          // R1 R2
        // Feedback division
        if (prescaler_mode == PLLD_MODE_FIXED_DIVIDE) begin
            if (b_count == {{(B_WIDTH-1){1'b0}}, 1'b1}) begin
                nxt_n = {{(B_WIDTH+1){1'b0}}, prescaler_p};             // R12
            end else begin
                // Widen before multiplying so the product is not cut to B bits
                nxt_n = (B_WIDTH+7)'(prescaler_p) * (B_WIDTH+7)'(b_count); // R13
            end
        end else begin
            nxt_n = (B_WIDTH+7)'(prescaler_p) * (B_WIDTH+7)'(b_count)
                + (B_WIDTH+7)'(a_count);                                // R14
        end
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            digital_lock_indicator <= 1'b0;
            lock_pin_val <= 1'b0;
            lock_pin_oe <= 1'b0;
            status_pin <= 1'b0;
            reference_monitor_pin <= 1'b0;
            ref_delay_code <= PLLD_DELAY_RST;
            fb_delay_code <= PLLD_DELAY_RST;
            n_total <= '0;
        end else begin
            digital_lock_indicator <= lock_ff;
            lock_pin_val <= nxt_lock_o;
            lock_pin_oe <= nxt_lock_oe;
            status_pin <= nxt_status;
            reference_monitor_pin <= nxt_reference_monitor_pin;
            ref_delay_code <= nxt_ref_code;
            fb_delay_code <= nxt_fb_code;
            n_total <= nxt_n;
        end
    end

    // ==========================================
    // Checks
    a_dly_off: assert property (@(posedge clk) disable iff (!rst_s_n) // R2
        !dly.ref_en |=> ref_delay_code == 3'h0) else $error("delay on");
    a_dig_follow: assert property (@(posedge clk) disable iff (!rst_s_n) // R3
        status_pin_sel == PLLD_SEL_DIGITAL ##1 $stable(status_pin_sel)
        |-> status_pin == $past(lock_ff)) else $error("status mux");
    a_analog_oe: assert property (@(posedge clk) disable iff (!rst_s_n) // R10
        lock_pin_sel == PLLD_SEL_ANALOG
        |=> lock_pin_oe == $past(mismatch)) else $error("analog oe");
    a_fd_bypass: assert property (@(posedge clk) disable iff (!rst_s_n) // R12
        prescaler_mode == PLLD_MODE_FIXED_DIVIDE && b_count == 1
        |=> n_total == $past(prescaler_p)) else $error("bypass");
    a_dm_sum: assert property (@(posedge clk) disable iff (!rst_s_n) // R14
        prescaler_mode == PLLD_MODE_DUAL_MODULUS && b_count == 3 && a_count == 1
        && prescaler_p == 2 |=> n_total == 7) else $error("sum");

endmodule

/* File: plld_pkg.sv */
// Package for the PLL lock detector and divider delay block
package plld_pkg;

    // ==========================================
    // Lock count selection (two-bit field)
    localparam logic [1:0] PLLD_CNT_SEL_RST = 2'h0;
    localparam logic [10:0] PLLD_CNT_5 = 11'h005;
    localparam logic [10:0] PLLD_CNT_16 = 11'h010;
    localparam logic [10:0] PLLD_CNT_64 = 11'h040;
    localparam logic [10:0] PLLD_CNT_255 = 11'h0FF;

    // ==========================================
    // Window widths in clk cycles per setting (lock narrower than unlock)
    localparam logic [7:0] PLLD_LOCK_WIN_BASE = 8'h02;
    localparam logic [7:0] PLLD_UNLOCK_WIN_BASE = 8'h05;
    localparam int PLLD_DELAY_BITS = 3;
    localparam logic [2:0] PLLD_DELAY_RST = 3'h0;
    localparam int PLLD_DELAY_RANGE_PS = 1000;

    // ==========================================
    // Pin mux selections
    typedef enum logic [1:0] {
        PLLD_SEL_LOW = 2'b00,
        PLLD_SEL_DIGITAL = 2'b01,
        PLLD_SEL_ANALOG = 2'b10,
        PLLD_SEL_HIGH = 2'b11
    } plld_sel_e;

    // Prescaler modes
    typedef enum logic [1:0] {
        PLLD_MODE_DUAL_MODULUS = 2'b00,
        PLLD_MODE_FIXED_DIVIDE = 2'b01
    } plld_mode_e;

    // Lock detector settings
    typedef struct packed {
        logic [1:0] cnt_sel;
        logic win_sel;
        logic [1:0] abl_width;
    } plld_cfg_s;

    // Divider delay settings
    typedef struct packed {
        logic ref_en;
        logic [2:0] ref_val;
        logic fb_en;
        logic [2:0] fb_val;
    } plld_dly_s;

endpackage

/* File: plld_top_tb.sv */
// Self-checking testbench for the PLL lock detector and divider delay block
`timescale 1ns/100ps
module pll_lock_detect_and_divider_delay_tb import plld_pkg::*; ;
    // ==========================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ref_edge = 1'b0;
    logic fb_edge = 1'b0;
    plld_cfg_s cfg = '0;
    plld_dly_s dly = '0;
    plld_sel_e lock_pin_sel = PLLD_SEL_LOW;
    plld_sel_e status_pin_sel = PLLD_SEL_LOW;
    plld_sel_e reference_monitor_pin_pin_sel = PLLD_SEL_LOW;
    logic analog_pullup_mode = 1'b0;
    plld_mode_e prescaler_mode = PLLD_MODE_DUAL_MODULUS;
    logic [5:0] prescaler_p = 6'h02;
    logic [5:0] a_count = 6'h00;
    logic [12:0] b_count = 13'h0003;
    logic digital_lock_indicator;
    logic lock_pin_val;
    logic lock_pin_oe;
    logic status_pin;
    logic reference_monitor_pin;
    logic [2:0] ref_delay_code;
    logic [2:0] fb_delay_code;
    logic [19:0] n_total;
    int mismatches = 0;
    int cmp_count = 0;

    // Clock of 100 ns period
    always begin
        #50 clk = ~clk;
    end

    plld_top #(.B_WIDTH(13)) u_dut (
        .clk(clk), .rst_n(rst_n), .ref_edge(ref_edge), .fb_edge(fb_edge),
        .cfg(cfg), .dly(dly), .lock_pin_sel(lock_pin_sel), .status_pin_sel(status_pin_sel),
        .reference_monitor_pin_pin_sel(reference_monitor_pin_pin_sel), .analog_pullup_mode(analog_pullup_mode),
        .prescaler_mode(prescaler_mode), .prescaler_p(prescaler_p), .a_count(a_count),
        .b_count(b_count), .digital_lock_indicator(digital_lock_indicator),
        .lock_pin_val(lock_pin_val), .lock_pin_oe(lock_pin_oe), .status_pin(status_pin),
        .reference_monitor_pin(reference_monitor_pin), .ref_delay_code(ref_delay_code),
        .fb_delay_code(fb_delay_code), .n_total(n_total)
    );

    // ==========================================
    // Shared tasks
    // Inputs always move 10 ns after the edge so sampling never races them
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One compare period: feedback edge rises d cycles after reference edge
    // The idle gap keeps the period well above the widest unlock window
    task automatic pd_cycle(input int d);
        ref_edge = 1'b1;
        if (d > 0) begin
            step(d);
        end
        fb_edge = 1'b1;
        step(3);
        ref_edge = 1'b0;
        fb_edge = 1'b0;
        step(25);
    endtask

    // Reference edge alone opens a mismatch; the lock pin is driven only during it
    task automatic analog_pulse(input logic [31:0] level);
        ref_edge = 1'b1;
        step(5);
        chk("lock_pin_oe in pulse", 32'(lock_pin_oe), 32'h1);
        chk("lock_pin_val in pulse", 32'(lock_pin_val), level);
        fb_edge = 1'b1;
        step(3);
        ref_edge = 1'b0;
        fb_edge = 1'b0;
        step(25);
    endtask

    // ==========================================
    // Scenarios
    // Delay codes follow the value only while the cell is enabled
    task automatic t_delay();
        for (int v = 0; v < 8; v++) begin
            dly = '{ref_en: 1'b1, ref_val: 3'(v), fb_en: 1'b0, fb_val: 3'(7 - v)};
            step(2);
            chk("ref_delay_code", 32'(ref_delay_code), 32'(v));
            chk("fb_delay_code off", 32'(fb_delay_code), 32'h0);
            dly = '{ref_en: 1'b0, ref_val: 3'(v), fb_en: 1'b1, fb_val: 3'(7 - v)};
            step(2);
            chk("fb_delay_code", 32'(fb_delay_code), 32'(7 - v));
            chk("ref_delay_code off", 32'(ref_delay_code), 32'h0);
        end
    endtask

    // Reset in mid-run clears the outputs, which stay clear for two edges after release
    task automatic t_reset();
        rst_n = 1'b0;
        step(1);
        chk("n_total in mid reset", 32'(n_total), 32'h0);
        chk("lock in mid reset", 32'(digital_lock_indicator), 32'h0);
        rst_n = 1'b1;
        step(1);
        chk("n_total held after release", 32'(n_total), 32'h0);
        step(2);
        chk("n_total after release", 32'(n_total), 32'h6);
    endtask

    // Division table: dual modulus, fixed divide, and counters bypassed with B of one
    task automatic t_divide();
        prescaler_mode = PLLD_MODE_DUAL_MODULUS;
        prescaler_p = 6'h02;
        a_count = 6'h01;
        b_count = 13'h0003;
        step(2);
        chk("n_total dual 2", 32'(n_total), 32'h7);
        prescaler_p = 6'h08;
        a_count = 6'h07;
        b_count = 13'h0012;
        step(2);
        chk("n_total dual 8", 32'(n_total), 32'h97);
        prescaler_p = 6'h20;
        a_count = 6'h06;
        b_count = 13'h002F;
        step(2);
        chk("n_total dual 32", 32'(n_total), 32'h5E6);
        prescaler_mode = PLLD_MODE_FIXED_DIVIDE;
        prescaler_p = 6'h02;
        a_count = 6'h05;
        b_count = 13'h0003;
        step(2);
        chk("n_total fixed", 32'(n_total), 32'h6);
        prescaler_p = 6'h10;
        b_count = 13'h0001;
        step(2);
        chk("n_total bypass", 32'(n_total), 32'h10);
    endtask

    // Count of five, narrow windows: lock, hysteresis, loss, pin muxes
    task automatic t_lock();
        cfg = '{cnt_sel: 2'h0, win_sel: 1'b0, abl_width: 2'h0};
        repeat (4) pd_cycle(0);
        chk("lock after four", 32'(digital_lock_indicator), 32'h0);
        pd_cycle(0);
        chk("lock after five", 32'(digital_lock_indicator), 32'h1);
        for (int s = 0; s < 4; s++) begin
            status_pin_sel = plld_sel_e'(s);
            reference_monitor_pin_pin_sel = plld_sel_e'(s);
            lock_pin_sel = plld_sel_e'(s);
            step(2);
            // Analog idles high in pull-down mode, and the lock pin is then released
            chk("status_pin", 32'(status_pin), 32'(s != 0));
            chk("reference_monitor_pin", 32'(reference_monitor_pin), 32'(s != 0));
            chk("lock_pin_val", 32'(lock_pin_val), 32'(s == 1 || s == 3));
            chk("lock_pin_oe", 32'(lock_pin_oe), 32'(s != 2));
        end
        status_pin_sel = PLLD_SEL_DIGITAL;
        reference_monitor_pin_pin_sel = PLLD_SEL_DIGITAL;
        repeat (2) pd_cycle(3);
        chk("lock held between windows", 32'(digital_lock_indicator), 32'h1);
        pd_cycle(12);
        chk("lock lost", 32'(digital_lock_indicator), 32'h0);
        chk("status_pin unlocked", 32'(status_pin), 32'h0);
        chk("reference_monitor_pin unlocked", 32'(reference_monitor_pin), 32'h0);
        repeat (4) pd_cycle(0);
        chk("relock restarts count", 32'(digital_lock_indicator), 32'h0);
    endtask

    // Wide windows: lock window 6, unlock window 14 cycles
    task automatic t_window();
        cfg = '{cnt_sel: 2'h0, win_sel: 1'b1, abl_width: 2'h1};
        lock_pin_sel = PLLD_SEL_ANALOG;
        pd_cycle(12);
        repeat (4) pd_cycle(3);
        chk("wide lock after four", 32'(digital_lock_indicator), 32'h0);
        pd_cycle(3);
        chk("wide lock after five", 32'(digital_lock_indicator), 32'h1);
        chk("analog idle pull-down", 32'(lock_pin_oe), 32'h0);
        analog_pulse(32'h0);
        pd_cycle(12);
        chk("wide unlock holds", 32'(digital_lock_indicator), 32'h1);
        analog_pullup_mode = 1'b1;
        pd_cycle(20);
        chk("wide unlock drops", 32'(digital_lock_indicator), 32'h0);
        chk("analog idle pull-up", 32'(lock_pin_oe), 32'h0);
        analog_pulse(32'h1);
    endtask

    // ==========================================
    // Main sequence and hang guard
    initial begin
        repeat (2) @(posedge clk);
        #10;
        chk("lock in reset", 32'(digital_lock_indicator), 32'h0);
        chk("n_total in reset", 32'(n_total), 32'h0);
        rst_n = 1'b1;
        step(3);
        t_delay();
        t_reset();
        t_divide();
        t_lock();
        t_window();
        end_of_test();
    end

    // A run that overstays its budget counts as a mismatch
    initial begin
        #(100 * 50000);
        mismatches++;
        end_of_test();
    end
endmodule
